// ### include/sram_pkg.sv
package sram_pkg;

  // Data path geometry
  localparam int unsigned WORD_W     = 18;
  localparam int unsigned LANE_W     = 9;
  localparam int unsigned LANES      = 2;
  localparam int unsigned BURST      = 4;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned FIFO_DEPTH = 4;

  // One clk period is one half of the primary clock period
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned PIPE_LEN      = 8;
  localparam int unsigned WR_DATA_TICK  = 2;
  localparam int unsigned LAT_DDR_TICKS = 5;
  localparam int unsigned LAT_SDR_TICKS = 2;
  localparam int unsigned WSEQ_LAST     = WR_DATA_TICK + BURST - 1;

  // Calibration, lock and clock-stop timing
  localparam int unsigned CAL_PERIOD   = 1024;
  localparam int unsigned LOCK_TIME_US = 100;
  localparam int unsigned LOCK_CYC     = (LOCK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STOP_TIME_NS = 30;
  localparam int unsigned STOP_CYC     = (STOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [LANES-1:0] MASK_NONE = 2'h3;

  typedef enum logic [2:0] {
    OP_NONE = 3'h1,
    OP_RD   = 3'h2,
    OP_WR   = 3'h4
  } op_t;

endpackage

// ### include/sram_if.sv
`timescale 1ns/100ps
interface sram_if;
  import sram_pkg::*;
  logic                      k_rise;
  logic                      k_run;
  logic [ADDR_W-1:0]         addr;
  logic                      read_select_n;
  logic                      write_select_n;
  logic [WORD_W-1:0]         d;
  logic [LANES-1:0]          lane_write_mask_n;
  logic                      pll_bypass_n;
  logic [WORD_W-1:0]         q;
  logic                      q_oe;
  logic                      output_valid_flag;
  logic                      echo_timing_out;
  logic                      echo_timing_out_n;

  modport device (
    input  k_rise, k_run, addr, read_select_n, write_select_n, d, lane_write_mask_n,
    input  pll_bypass_n,
    output q, q_oe, output_valid_flag, echo_timing_out, echo_timing_out_n
  );

  modport host (
    output k_rise, k_run, addr, read_select_n, write_select_n, d, lane_write_mask_n,
    output pll_bypass_n,
    input  q, q_oe, output_valid_flag, echo_timing_out, echo_timing_out_n
  );
endinterface

// ### logic/sram_port_device.sv
`timescale 1ns/100ps
module sram_port_device
  import sram_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES = LOCK_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Link to the controller
  sram_if.device    bus,
  // Status
  output logic      pll_locked,
  output logic      impedance_update
);

  logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];

  op_t               prev_op_r;
  logic [PIPE_LEN-1:0] rd_v_r;
  logic [PIPE_LEN-1:0] wr_v_r;
  logic [ADDR_W-1:0] addr_pipe_r [0:PIPE_LEN-1];
  logic              tick;
  logic              start_rd;
  logic              start_wr;
  logic [PIPE_LEN:0] rd_ext;
  logic [PIPE_LEN:0] wr_ext;
  logic [ADDR_W-1:0] ext_addr [0:PIPE_LEN];
  int unsigned       lat;
  logic              rd_hit;
  logic              vld_nxt;
  logic [ADDR_W-1:0] rd_a;
  logic              wr_hit;
  logic [ADDR_W-1:0] wr_a;
  logic [WORD_W-1:0] wr_merge;
  logic [WORD_W-1:0] rd_data;
  logic [WORD_W-1:0] q_r;
  logic              q_oe_r;
  logic              vld_r;
  logic              echo_r;
  logic              echo_n_r;
  logic [31:0]       lock_cnt_r;
  logic [1:0]        stop_cnt_r;
  logic              locked_r;
  logic [9:0]        cal_cnt_r;
  logic              cal_r;

  // A stopped link clock freezes every transaction in place
  assign tick = bus.k_run;

  // Selects only count on a primary rise; a port that started last rise is ignored
  assign start_rd = tick && bus.k_rise && !bus.read_select_n
                    && (prev_op_r != OP_RD);
  assign start_wr = tick && bus.k_rise && !bus.write_select_n
                    && (prev_op_r != OP_WR) && !start_rd;

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_op_r <= OP_NONE;
    end else if (tick && bus.k_rise) begin
      if (start_rd) begin
        prev_op_r <= OP_RD;
      end else if (start_wr) begin
        prev_op_r <= OP_WR;
      end else begin
        prev_op_r <= OP_NONE;
      end
    end
  end

  // Started bursts ride this pipe to completion regardless of later selects
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_v_r <= '0;
      wr_v_r <= '0;
      for (int i = 0; i < PIPE_LEN; i++) begin
        addr_pipe_r[i] <= '0;
      end
    end else if (tick) begin
      rd_v_r <= {rd_v_r[PIPE_LEN-2:0], start_rd};
      wr_v_r <= {wr_v_r[PIPE_LEN-2:0], start_wr};
      addr_pipe_r[0] <= bus.addr;
      for (int i = 1; i < PIPE_LEN; i++) begin
        addr_pipe_r[i] <= addr_pipe_r[i-1];
      end
    end
  end

  assign rd_ext = {rd_v_r, start_rd};
  assign wr_ext = {wr_v_r, start_wr};

  always_comb begin
    ext_addr[0] = bus.addr;
    for (int i = 1; i <= PIPE_LEN; i++) begin
      ext_addr[i] = addr_pipe_r[i-1];
    end
  end

  // Bypass low disables the PLL and shortens read latency
  assign lat = bus.pll_bypass_n ? LAT_DDR_TICKS : LAT_SDR_TICKS;

  always_comb begin
    rd_hit  = 1'b0;
    vld_nxt = 1'b0;
    rd_a    = '0;
    wr_hit  = 1'b0;
    wr_a    = '0;
    for (int j = 0; j < BURST; j++) begin
      if (rd_ext[lat-1+j]) begin
        rd_hit = 1'b1;
        rd_a   = ext_addr[lat-1+j] + ADDR_W'(j);
      end
      if (rd_ext[lat-2+j]) begin
        vld_nxt = 1'b1;
      end
      if (wr_ext[WR_DATA_TICK+j]) begin
        wr_hit = 1'b1;
        wr_a   = ext_addr[WR_DATA_TICK+j] + ADDR_W'(j);
      end
    end
  end

  // Masks are sampled together with the word they qualify
  genvar l;
  generate
    for (l = 0; l < LANES; l++) begin : g_lane
      assign wr_merge[l*LANE_W +: LANE_W] = bus.lane_write_mask_n[l]
                                            ? mem[wr_a][l*LANE_W +: LANE_W]
                                            : bus.d[l*LANE_W +: LANE_W];
    end
  endgenerate

  // Same-edge hit on the landing write word is forwarded past the array
  assign rd_data = (wr_hit && (wr_a == rd_a)) ? wr_merge : mem[rd_a];

  always_ff @(posedge clk) begin
    if (tick && wr_hit) begin
      mem[wr_a] <= wr_merge;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_r    <= '0;
      q_oe_r <= 1'b0;
      vld_r  <= 1'b0;
    end else if (tick) begin
      q_r    <= rd_hit ? rd_data : '0;
      q_oe_r <= rd_hit;
      vld_r  <= vld_nxt;
    end
  end

  // Echo clocks run while the link clock runs, one per input phase
  always_ff @(posedge clk) begin
    if (rst) begin
      echo_r   <= 1'b0;
      echo_n_r <= 1'b1;
    end else if (tick) begin
      echo_r   <= bus.k_rise;
      echo_n_r <= !bus.k_rise;
    end
  end

  // Lock timer restarts after the inputs stall long enough
  always_ff @(posedge clk) begin
    if (rst) begin
      stop_cnt_r <= '0;
    end else if (tick) begin
      stop_cnt_r <= '0;
    end else if (stop_cnt_r != 2'(STOP_CYC)) begin
      stop_cnt_r <= stop_cnt_r + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lock_cnt_r <= '0;
      locked_r   <= 1'b0;
    end else begin
      if (stop_cnt_r == 2'(STOP_CYC)) begin
        lock_cnt_r <= '0;
      end else if (tick && bus.pll_bypass_n && lock_cnt_r != LOCK_CYCLES) begin
        lock_cnt_r <= lock_cnt_r + 32'h1;
      end
      locked_r <= !bus.pll_bypass_n || (lock_cnt_r == LOCK_CYCLES);
    end
  end

  // Free-running recalibration strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      cal_cnt_r <= '0;
      cal_r     <= 1'b0;
    end else begin
      cal_cnt_r <= cal_cnt_r + 10'h1;
      cal_r     <= (cal_cnt_r == 10'(CAL_PERIOD - 1));
    end
  end

  assign bus.q                 = q_r;
  assign bus.q_oe              = q_oe_r;
  assign bus.output_valid_flag = vld_r;
  assign bus.echo_timing_out   = echo_r;
  assign bus.echo_timing_out_n = echo_n_r;
  assign pll_locked            = locked_r;
  assign impedance_update      = cal_r;

endmodule

// ### logic/sram_port_host.sv
`timescale 1ns/100ps
module read_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  empty
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PW-1:0]    wp_r;
  logic [PW-1:0]    rp_r;
  logic [PW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign empty     = (cnt_r == '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = store[rp_r];

  always_ff @(posedge clk) begin
    if (push) begin
      store[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + PW'(1);
      end
      if (pop) begin
        rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + PW'(1);
      end
      cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

module sram_port_host
  import sram_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Link to the memory
  sram_if.host                         bus,
  // Link clock control
  input  wire logic                    clk_run,
  input  wire logic                    legacy_mode,
  // Command
  input  wire logic                    cmd_valid,
  output logic                         cmd_ready,
  input  wire logic                    cmd_write,
  input  wire logic [ADDR_W-1:0]       cmd_addr,
  input  wire logic [BURST*WORD_W-1:0] cmd_data,
  input  wire logic [BURST*LANES-1:0]  cmd_mask_n,
  // Read data
  output logic                         rd_valid,
  input  wire logic                    rd_ready,
  output logic [WORD_W-1:0]            rd_data
);

  logic                    k_rise_r;
  logic                    k_run_r;
  logic                    next_rise;
  op_t                     prev_op_r;
  logic                    can_rd;
  logic                    can_wr;
  logic                    issue;
  logic                    rsel_n_r;
  logic                    wsel_n_r;
  logic [ADDR_W-1:0]       addr_r;
  logic [2:0]              wseq_r;
  logic [BURST*WORD_W-1:0] wd_r;
  logic [BURST*LANES-1:0]  wm_r;
  logic [WORD_W-1:0]       d_r;
  logic [LANES-1:0]        mask_r;
  logic                    vld_d_r;
  logic                    push;
  logic                    rd_busy_r;
  logic [2:0]              rd_cnt_r;
  logic                    fifo_in_ready;
  logic                    fifo_empty;

  assign next_rise = clk_run && (k_run_r ? !k_rise_r : k_rise_r);

  always_ff @(posedge clk) begin
    if (rst) begin
      k_rise_r <= 1'b0;
      k_run_r  <= 1'b0;
    end else begin
      k_run_r <= clk_run;
      if (k_run_r) begin
        k_rise_r <= !k_rise_r;
      end
    end
  end

  // Reads wait for an empty FIFO so a whole burst always has room
  assign can_rd = !rd_busy_r && fifo_empty && fifo_in_ready && (prev_op_r != OP_RD);
  assign can_wr = (wseq_r == 3'h0) && (prev_op_r != OP_WR);
  assign issue  = next_rise && cmd_valid && (cmd_write ? can_wr : can_rd);
  assign cmd_ready = issue;

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_op_r <= OP_NONE;
      rsel_n_r  <= 1'b1;
      wsel_n_r  <= 1'b1;
      addr_r    <= '0;
      wd_r      <= '0;
      wm_r      <= '1;
    end else begin
      rsel_n_r <= !(issue && !cmd_write);
      wsel_n_r <= !(issue && cmd_write);
      if (next_rise) begin
        prev_op_r <= !issue ? OP_NONE : (cmd_write ? OP_WR : OP_RD);
      end
      if (issue) begin
        addr_r <= cmd_addr;
      end
      if (issue && cmd_write) begin
        wd_r <= cmd_data;
        wm_r <= cmd_mask_n;
      end
    end
  end

  // Write words and their masks go out on four edges, starting two ticks after the address
  always_ff @(posedge clk) begin
    if (rst) begin
      wseq_r <= '0;
      d_r    <= '0;
      mask_r <= MASK_NONE;
    end else begin
      if (issue && cmd_write) begin
        wseq_r <= 3'h1;
      end else if (k_run_r && wseq_r != 3'h0) begin
        wseq_r <= (wseq_r == 3'(WSEQ_LAST)) ? 3'h0 : wseq_r + 3'h1;
      end
      if (k_run_r && wseq_r >= 3'(WR_DATA_TICK)) begin
        d_r    <= wd_r[(int'(wseq_r) - WR_DATA_TICK)*WORD_W +: WORD_W];
        mask_r <= wm_r[(int'(wseq_r) - WR_DATA_TICK)*LANES +: LANES];
      end
    end
  end

  // The valid flag leads data by one tick, so its delayed copy marks the word
  assign push = k_run_r && vld_d_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      vld_d_r   <= 1'b0;
      rd_busy_r <= 1'b0;
      rd_cnt_r  <= '0;
    end else begin
      if (k_run_r) begin
        vld_d_r <= bus.output_valid_flag;
      end
      if (issue && !cmd_write) begin
        rd_busy_r <= 1'b1;
        rd_cnt_r  <= '0;
      end else if (push) begin
        rd_cnt_r <= rd_cnt_r + 3'h1;
        if (rd_cnt_r == 3'(BURST - 1)) begin
          rd_busy_r <= 1'b0;
        end
      end
    end
  end

  read_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (bus.q),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data),
    .empty     (fifo_empty)
  );

  assign bus.k_rise            = k_rise_r;
  assign bus.k_run             = k_run_r;
  assign bus.addr              = addr_r;
  assign bus.read_select_n     = rsel_n_r;
  assign bus.write_select_n    = wsel_n_r;
  assign bus.d                 = d_r;
  assign bus.lane_write_mask_n = mask_r;
  assign bus.pll_bypass_n      = !legacy_mode;

endmodule

// ### verification/sram_port_chk.sv
`timescale 1ns/100ps
module sram_port_chk
  import sram_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES = 20
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // Link
  input wire logic              k_rise,
  input wire logic              k_run,
  input wire logic              read_select_n,
  input wire logic              write_select_n,
  input wire logic              pll_bypass_n,
  input wire logic [WORD_W-1:0] q,
  input wire logic              q_oe,
  input wire logic              output_valid_flag,
  input wire logic              echo_timing_out,
  input wire logic              echo_timing_out_n,
  // Status
  input wire logic              pll_locked,
  input wire logic              impedance_update
);
  logic [10:0] cal_cnt_r;
  logic        cal_seen_r;
  logic [7:0]  lock_cnt_r;
  logic        rd_start;

  assign rd_start = k_run && k_rise && !read_select_n;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  always_ff @(posedge clk) begin
    if (rst || impedance_update) cal_cnt_r <= 11'h0;
    else cal_cnt_r <= cal_cnt_r + 11'h1;
  end

  always_ff @(posedge clk) begin
    if (rst) cal_seen_r <= 1'b0;
    else if (impedance_update) cal_seen_r <= 1'b1;
  end

  // Any stop clears it, so a one-cycle gap would also restart the wait
  always_ff @(posedge clk) begin
    if (rst || !k_run) lock_cnt_r <= 8'h0;
    else if (lock_cnt_r != 8'hff) lock_cnt_r <= lock_cnt_r + 8'h1;
  end

  property p_echo_follow; k_run |=> echo_timing_out == $past(k_rise); endproperty
  property p_echo_pair; echo_timing_out_n == !echo_timing_out; endproperty
  property p_rd_lat;
    rd_start && pll_bypass_n |-> (!output_valid_flag)[*4] ##1 output_valid_flag[*4]
      ##1 !output_valid_flag;
  endproperty
  property p_rd_leg; rd_start && !pll_bypass_n |-> !q_oe ##2 q_oe[*4] ##1 !q_oe; endproperty
  property p_flag_lead; $rose(output_valid_flag) |-> !q_oe ##1 q_oe[*2]; endproperty
  property p_flag_tail; $fell(output_valid_flag) |-> q_oe ##1 !q_oe; endproperty
  property p_idle_q; !q_oe |-> q == '0; endproperty
  property p_one_start; read_select_n || write_select_n; endproperty
  property p_sel_primary; !read_select_n || !write_select_n |-> k_rise && k_run; endproperty
  property p_cal;
    cal_seen_r |-> (impedance_update ? cal_cnt_r == 11'h3ff : cal_cnt_r < 11'h3ff);
  endproperty
  property p_lock; pll_bypass_n && lock_cnt_r == 8'(LOCK_CYCLES + 3) |-> pll_locked; endproperty

  a_echo_follow: assert property (p_echo_follow) else $error("echo clock lags phase");
  a_echo_pair: assert property (p_echo_pair) else $error("echo pair not inverse");
  a_rd_lat: assert property (p_rd_lat) else $error("read latency wrong");
  a_rd_leg: assert property (p_rd_leg) else $error("legacy latency wrong");
  a_flag_lead: assert property (p_flag_lead) else $error("valid flag not ahead");
  a_flag_tail: assert property (p_flag_tail) else $error("burst cut short");
  a_idle_q: assert property (p_idle_q) else $error("read data while idle");
  a_one_start: assert property (p_one_start) else $error("two starts at once");
  a_sel_primary: assert property (p_sel_primary) else $error("select off primary");
  a_cal: assert property (p_cal) else $error("calibration period wrong");
  a_lock: assert property (p_lock) else $error("lock not reached");

  c_rd_pll: cover property (rd_start && pll_bypass_n);
  c_rd_leg: cover property (rd_start && !pll_bypass_n);
  c_wr: cover property (k_run && k_rise && !write_select_n);
endmodule

// ### verification/sync_sram_port_sequencer_bench.sv
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module sync_sram_port_sequencer_bench
  import sram_pkg::*;
;
  typedef struct packed {
    logic                    leg;
    logic                    wr;
    logic [ADDR_W-1:0]       addr;
    logic [BURST*WORD_W-1:0] data;
    logic [BURST*LANES-1:0]  mask;
  } row_t;

  logic                    clk = 1'b0;
  logic                    rst;
  logic                    clk_run;
  logic                    legacy_mode;
  logic                    cmd_valid;
  logic                    cmd_ready;
  logic                    cmd_write;
  logic [ADDR_W-1:0]       cmd_addr;
  logic [BURST*WORD_W-1:0] cmd_data;
  logic [BURST*LANES-1:0]  cmd_mask_n;
  logic                    rd_valid;
  logic                    rd_ready;
  logic [WORD_W-1:0]       rd_data;
  logic                    pll_locked;
  logic                    impedance_update;
  logic [WORD_W-1:0]       mem [256];
  logic [WORD_W-1:0]       q2 [$];
  int                      err_count = 0;
  int                      check_count = 0;
  // Word lanes of each write: mask 8'h93 leaves word0 alone and splits words 2 and 3
  row_t rows [8] = '{
    '{1'b0, 1'b1, 8'h10, 72'h123456789abcdef012, 8'h00},
    '{1'b0, 1'b0, 8'h10, 72'h0, 8'h00},
    '{1'b0, 1'b1, 8'h10, 72'hfedcba9876543210ab, 8'h93},
    '{1'b0, 1'b0, 8'h10, 72'h0, 8'h00},
    '{1'b0, 1'b1, 8'hfe, 72'h0f1e2d3c4b5a697887, 8'h00},
    '{1'b0, 1'b0, 8'hfe, 72'h0, 8'h00},
    '{1'b1, 1'b1, 8'h40, 72'h2468ace013579bdf11, 8'h00},
    '{1'b1, 1'b0, 8'h40, 72'h0, 8'h00}};
  // Selects per primary tick of the direct link, bit1 read, bit0 write
  logic [1:0]        sel2 [10] = '{2'h2, 2'h3, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h1, 2'h1};
  logic [ADDR_W-1:0] adr2 [10] = '{8'h20, 8'h0, 8'h0, 8'h20, 8'h40, 8'h40, 8'h60, 8'h0,
                                   8'h20, 8'h40};

  sram_if bus ();
  sram_if bus2 ();

  sram_port_device #(.LOCK_CYCLES(20)) sram_port_device_i (
    .clk(clk), .rst(rst), .bus(bus), .pll_locked(pll_locked),
    .impedance_update(impedance_update));
  // Second device faces the bench alone so arbitration and misuse can be forced
  sram_port_device #(.LOCK_CYCLES(20)) sram_port_device_i2 (
    .clk(clk), .rst(rst), .bus(bus2), .pll_locked(), .impedance_update());
  sram_port_host sram_port_host_i (
    .clk(clk), .rst(rst), .bus(bus), .clk_run(clk_run), .legacy_mode(legacy_mode),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_mask_n(cmd_mask_n),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
  sram_port_chk #(.LOCK_CYCLES(20)) sram_port_chk_i (
    .clk(clk), .rst(rst), .k_rise(bus.k_rise), .k_run(bus.k_run),
    .read_select_n(bus.read_select_n), .write_select_n(bus.write_select_n),
    .pll_bypass_n(bus.pll_bypass_n), .q(bus.q), .q_oe(bus.q_oe),
    .output_valid_flag(bus.output_valid_flag), .echo_timing_out(bus.echo_timing_out),
    .echo_timing_out_n(bus.echo_timing_out_n), .pll_locked(pll_locked),
    .impedance_update(impedance_update));

  always #10 clk = ~clk;

  always @(posedge clk) begin
    if (bus2.q_oe === 1'b1) q2.push_back(bus2.q);
  end

  task automatic end_of_test();
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic send(input row_t r);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_write <= r.wr;
    cmd_addr <= r.addr;
    cmd_data <= r.data;
    cmd_mask_n <= r.mask;
    do begin
      @(posedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 60);
    `CHK(cmd_ready, 1'b1)
    cmd_valid <= 1'b0;
  endtask

  task automatic store(input row_t r);
    logic [ADDR_W-1:0] a;
    a = r.addr;
    for (int j = 0; j < BURST; j++) begin
      for (int l = 0; l < LANES; l++) begin
        if (!r.mask[j*LANES+l])
          mem[a][l*LANE_W +: LANE_W] = r.data[j*WORD_W+l*LANE_W +: LANE_W];
      end
      a++;
    end
  endtask

  // Words pile up in the buffer first, so a full buffer must hold off new reads
  task automatic take(input row_t r);
    logic [ADDR_W-1:0] a;
    int                n;
    int                got;
    a = r.addr;
    n = 0;
    got = 0;
    // A second read stays offered while the burst fills the buffer
    for (int k = 0; k < 20; k++) begin
      @(posedge clk);
      if (cmd_ready !== 1'b0) n++;
      cmd_valid <= (k < 19);
    end
    `CHK(n, 0)
    rd_ready <= 1'b1;
    while (got < BURST && n < 60) begin
      @(posedge clk);
      n++;
      if (rd_valid === 1'b1) begin
        `CHK(rd_data, mem[a])
        a++;
        got++;
      end
    end
    rd_ready <= 1'b0;
    @(posedge clk);
    `CHK({rd_valid, got[3:0]}, 5'h04)
  endtask

  initial begin
    repeat (10000) @(posedge clk);
    err_count++;
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    clk_run = 1'b0;
    legacy_mode = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = '0;
    cmd_data = '0;
    cmd_mask_n = '0;
    rd_ready = 1'b0;
    bus2.k_run = 1'b1;
    bus2.k_rise = 1'b0;
    bus2.addr = '0;
    bus2.read_select_n = 1'b1;
    bus2.write_select_n = 1'b1;
    bus2.d = '0;
    bus2.lane_write_mask_n = '0;
    bus2.pll_bypass_n = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK({bus.q_oe, bus.read_select_n, bus.write_select_n, rd_valid, pll_locked}, 5'h0c)
    clk_run <= 1'b1;
    repeat (30) @(posedge clk);
    `CHK(pll_locked, 1'b1)
    foreach (rows[i]) begin
      legacy_mode <= rows[i].leg;
      @(posedge clk);
      send(rows[i]);
      if (rows[i].wr) store(rows[i]);
      else take(rows[i]);
    end
    legacy_mode <= 1'b0;
    @(posedge clk);
    clk_run <= 1'b0;
    repeat (4) @(posedge clk);
    clk_run <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(pll_locked, 1'b0)
    repeat (30) @(posedge clk);
    `CHK(pll_locked, 1'b1)
    for (int k = 0; k < 40; k++) begin
      @(posedge clk);
      bus2.k_rise <= ~k[0];
      // Both selects low on an inverse tick must start nothing
      {bus2.read_select_n, bus2.write_select_n} <= (k == 21) ? 2'h0 :
                                                   (k[0] || k >= 20) ? 2'h3 : sel2[k/2];
      bus2.addr <= (k < 20) ? adr2[k/2] : 8'h0;
      bus2.d <= 18'h100 + 18'(k);
    end
    `CHK(q2.size(), 12)
    foreach (q2[j]) begin
      `CHK(q2[j], 18'h102 + 18'(j % 4) + ((j / 4 == 1) ? 18'h8 : 18'h0))
    end
    repeat (2100) @(posedge clk);
    end_of_test();
  end
endmodule
